// ---- logic/sfb_pkg.sv ----
`default_nettype none
package sfb_pkg;
  // apb register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_CMD_LO = 8'h08;
  localparam logic [7:0] REG_CMD_HI = 8'h0c;
  localparam logic [7:0] REG_RSP_LO = 8'h10;
  localparam logic [7:0] REG_RSP_HI = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  // field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_DUAL = 1;
  localparam int STAT_BOOT = 0;
  localparam int STAT_EXT = 1;
  localparam int STAT_FAST = 2;
  localparam int STAT_CS = 3;
  // reset values
  localparam logic [7:0] LEN_RST = 8'h00;
  localparam logic [63:0] CMD_RST = 64'h0;
  localparam logic [63:0] RSP_RST = 64'h0;
  // flash protocol
  localparam int LEN_W = 8;
  localparam int BUF_BYTES = 8;
  localparam logic [7:0] OP_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL = 8'h3b;
  localparam logic [7:0] DONT_CARE = 8'h00;
  localparam logic [LEN_W-1:0] IDX_DUMMY = 8'd4;
  localparam logic [LEN_W-1:0] IDX_DATA = 8'd5;
  localparam logic [LEN_W-1:0] IDX_SIG_LAST = 8'd8;
  localparam logic [2:0] LAST_BIT_SINGLE = 3'd7;
  localparam logic [2:0] LAST_BIT_DUAL = 3'd3;
  // boot signature "2DFU"
  localparam logic [23:0] SIG_ADDR = 24'h00fffa;
  localparam logic [31:0] SIG_VALUE = 32'h32444655;
  // fetch cache
  localparam int CACHE_DEPTH = 32;
  localparam int CACHE_IDX_W = 5;
  // serial clock half period in pclk cycles per speed strap
  localparam int SCK_HALF_SLOW = 4;
  localparam int SCK_HALF_FAST = 3;
  localparam logic [1:0] STRAP_LATCH = 2'd2;
  localparam logic [1:0] STRAP_READY = 2'd3;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HOLD, ST_END} sfb_state_type;
  typedef enum logic [1:0] {MODE_BOOT, MODE_FETCH, MODE_BUF} sfb_mode_type;
endpackage : sfb_pkg
`default_nettype wire

// ---- logic/sfb_cache_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface sfb_cache_if #(
  parameter int IDX_W = 5
) ();
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : sfb_cache_if
`default_nettype wire

// ---- logic/sfb_cache_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
module sfb_cache_mem #(
  parameter int DEPTH = 32
) (
  // clock
  input wire logic pclk,
  // cache port
  sfb_cache_if.mem cif
);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sfb_cache_mem: depth must be a power of two");
  end
  logic [7:0] mem_q [DEPTH];
  always_ff @(posedge pclk) begin
    if (cif.wr_en) begin
      mem_q[cif.wr_idx] <= cif.wr_data;
    end
  end
  // registered read gives the one-cycle hit answer
  always_ff @(posedge pclk) begin
    cif.rd_data <= mem_q[cif.rd_idx];
  end
endmodule : sfb_cache_mem
`default_nettype wire

// ---- logic/sfb_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module sfb_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sfb_sync
`default_nettype wire

// ---- logic/sfb_flash_fetch.sv ----
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - boot signature at 0xfffa gates external execution
// - valid signature starts fetch, else internal
// - single read: opcode, address, dummy, bytes
// - ready after first byte, one byte taken
// - sequential address streams one more byte
// - non-sequential address raises chip select
// - dual read only at slow clock speed
// - dual read: 0x3b, bytes in four clocks
// - jump loads cache base pointer
// - cache keeps newest 32 sequential bytes
// - cache hit answers in one clock from idle, three when a stream is held
// - command, response buffers and length register
// - start bit issues length times eight clocks
// - bytes after command go to response
// - beyond command buffer send don't-care bytes
// - erase commands: opcode, address, length four
// - byte program: length five, input unused
// - single opcode commands use length one
// - id read leaves three response bytes
// - chip select high after buffered transfer
// - reset ends everything, registers to defaults
// - speed strap latched after reset release
module sfb_flash_fetch #(
  parameter int HALF_SLOW = sfb_pkg::SCK_HALF_SLOW,
  parameter int HALF_FAST = sfb_pkg::SCK_HALF_FAST
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sfb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor fetch port
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  output logic fetch_ready,
  output logic [7:0] fetch_data,
  output logic fetch_busy,
  // boot status
  output logic boot_done,
  output logic ext_exec_en,
  // serial flash pins
  output logic flash_cs_n,
  output logic flash_sclk,
  output logic serial_out_o,
  output logic serial_out_oe,
  input wire logic serial_out_i,
  input wire logic serial_in_line,
  input wire logic serial_speed_strap
);
  import sfb_pkg::*;

  // sampling needs two sync stages inside the high phase
  if (HALF_SLOW < 3 || HALF_FAST < 3 || HALF_SLOW > 16 || HALF_FAST > 16) begin : g_bad_half
    $error("sfb_flash_fetch: half periods must be 3 to 16");
  end

  sfb_state_type st_q;
  sfb_mode_type mode_q;
  logic [3:0] cnt_q;
  logic sclk_q;
  logic cs_n_q;
  logic [2:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [LEN_W-1:0] idx_q;
  logic dual_sel_q;
  logic dual_data_q;
  logic [23:0] addr_q;
  logic jump_q;
  logic pend_q;
  logic [23:0] pend_addr_q;
  logic ready_q;
  logic hit_q;
  logic [7:0] data_q;
  logic [23:0] base_q;
  logic [5:0] clen_q;
  logic ctrl_dual_q;
  logic busy_q;
  logic [LEN_W-1:0] len_q;
  logic [63:0] cmd_q;
  logic [63:0] rsp_q;
  logic boot_done_q;
  logic ext_q;
  logic [31:0] sig_q;
  logic strap_fast_q;
  logic [1:0] strap_cnt_q;
  logic si_s;
  logic so_s;
  logic strap_s;

  sfb_sync #(.WIDTH(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({serial_in_line, serial_out_i, serial_speed_strap}),
    .q({si_s, so_s, strap_s})
  );

  sfb_cache_if #(.IDX_W(CACHE_IDX_W)) cif ();
  sfb_cache_mem #(.DEPTH(CACHE_DEPTH)) u_cache (
    .pclk(pclk),
    .cif(cif)
  );

  logic [3:0] half_m1;
  logic tick;
  logic rise;
  logic fall;
  logic last_bit;
  logic byte_done;
  logic [7:0] rx_next;
  logic [LEN_W-1:0] idx_nx;
  logic [LEN_W-1:0] idx_m1;
  logic fetch_ok;
  logic dual_ok;
  logic cur_req;
  logic [23:0] cur_addr;
  logic cur_hit;
  logic seq_req;
  logic cache_wr;
  logic strap_ok;
  logic apb_wr;

  assign half_m1 = strap_fast_q ? 4'(HALF_FAST - 1) : 4'(HALF_SLOW - 1);
  assign tick = (st_q == ST_SHIFT) && (cnt_q == half_m1);
  assign rise = tick && !sclk_q;
  assign fall = tick && sclk_q;
  assign last_bit = bit_q == (dual_data_q ? LAST_BIT_DUAL : LAST_BIT_SINGLE);
  assign byte_done = fall && last_bit;
  // in dual data phase the high bit of each pair comes on the input line
  assign rx_next = dual_data_q ? {rx_q[5:0], si_s, so_s} : {rx_q[6:0], si_s};
  assign idx_nx = idx_q + 1'b1;
  assign idx_m1 = idx_q - 1'b1;
  assign fetch_ok = boot_done_q && ext_q;
  assign dual_ok = ctrl_dual_q && !strap_fast_q;
  assign cur_req = fetch_req || pend_q;
  assign cur_addr = fetch_req ? fetch_addr : pend_addr_q;
  assign cur_hit = (cur_addr - base_q) < 24'(clen_q);
  assign seq_req = fetch_req && (fetch_addr == addr_q + 24'd1);
  assign cache_wr = byte_done && mode_q == MODE_FETCH && idx_q >= IDX_DATA;
  assign strap_ok = strap_cnt_q == STRAP_READY;
  assign apb_wr = psel && penable && pwrite;

  function automatic logic [7:0] hdr_byte(input logic [LEN_W-1:0] i, input logic [23:0] a);
    case (i)
      8'd1: hdr_byte = a[23:16];
      8'd2: hdr_byte = a[15:8];
      8'd3: hdr_byte = a[7:0];
      default: hdr_byte = DONT_CARE;
    endcase
  endfunction : hdr_byte

  function automatic logic [7:0] buf_byte(input logic [LEN_W-1:0] i, input logic [63:0] c);
    buf_byte = (i < BUF_BYTES) ? c[{i[2:0], 3'b000} +: 8] : DONT_CARE;
  endfunction : buf_byte

  // strap is caught a sync delay after reset release, then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'd0;
      strap_fast_q <= 1'b0;
    end else if (!strap_ok) begin
      strap_cnt_q <= strap_cnt_q + 2'd1;
      if (strap_cnt_q == STRAP_LATCH) begin
        strap_fast_q <= strap_s;
      end
    end
  end

  // serial clock divider and receive shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'd0;
      sclk_q <= 1'b0;
      bit_q <= 3'd0;
      rx_q <= 8'h00;
    end else begin
      cnt_q <= (st_q == ST_SHIFT && !tick) ? cnt_q + 4'd1 : 4'd0;
      if (rise) begin
        sclk_q <= 1'b1;
      end
      if (fall) begin
        sclk_q <= 1'b0;
        rx_q <= rx_next;
        bit_q <= last_bit ? 3'd0 : bit_q + 3'd1;
      end
    end
  end

  // transaction sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      mode_q <= MODE_BOOT;
      cs_n_q <= 1'b1;
      tx_q <= 8'h00;
      idx_q <= '0;
      dual_sel_q <= 1'b0;
      dual_data_q <= 1'b0;
      addr_q <= 24'h0;
      jump_q <= 1'b0;
      pend_q <= 1'b0;
      pend_addr_q <= 24'h0;
      ready_q <= 1'b0;
      hit_q <= 1'b0;
      data_q <= 8'h00;
    end else begin
      ready_q <= 1'b0;
      if (fetch_req && fetch_ok && (st_q == ST_IDLE || st_q == ST_HOLD)) begin
        pend_q <= 1'b1;
        pend_addr_q <= fetch_addr;
      end
      case (st_q)
        ST_IDLE: begin
          if (!boot_done_q) begin
            if (strap_ok) begin
              mode_q <= MODE_BOOT;
              addr_q <= SIG_ADDR;
              tx_q <= OP_READ;
              idx_q <= '0;
              cs_n_q <= 1'b0;
              st_q <= ST_SHIFT;
            end
          end else if (fetch_ok && cur_req && cur_hit) begin
            ready_q <= 1'b1;
            hit_q <= 1'b1;
            pend_q <= 1'b0;
            addr_q <= cur_addr;
          end else if (busy_q) begin
            mode_q <= MODE_BUF;
            tx_q <= buf_byte('0, cmd_q);
            idx_q <= '0;
            cs_n_q <= 1'b0;
            st_q <= ST_SHIFT;
          end else if (fetch_ok && cur_req) begin
            mode_q <= MODE_FETCH;
            addr_q <= cur_addr;
            dual_sel_q <= dual_ok;
            tx_q <= dual_ok ? OP_DUAL : OP_READ;
            idx_q <= '0;
            jump_q <= 1'b1;
            pend_q <= 1'b0;
            cs_n_q <= 1'b0;
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (fall && !last_bit && !dual_data_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
          end
          if (byte_done) begin
            if (mode_q == MODE_BUF) begin
              if (idx_nx == len_q) begin
                cs_n_q <= 1'b1;
                st_q <= ST_END;
              end else begin
                idx_q <= idx_nx;
                tx_q <= buf_byte(idx_nx, cmd_q);
              end
            end else if (idx_q < IDX_DUMMY) begin
              idx_q <= idx_nx;
              tx_q <= hdr_byte(idx_nx, addr_q);
            end else if (idx_q == IDX_DUMMY) begin
              idx_q <= IDX_DATA;
              dual_data_q <= mode_q == MODE_FETCH && dual_sel_q;
            end else if (mode_q == MODE_FETCH) begin
              data_q <= rx_next;
              ready_q <= 1'b1;
              hit_q <= 1'b0;
              st_q <= ST_HOLD;
            end else if (idx_q == IDX_SIG_LAST) begin
              cs_n_q <= 1'b1;
              st_q <= ST_END;
            end else begin
              idx_q <= idx_nx;
            end
          end
        end
        ST_HOLD: begin
          if (seq_req) begin
            addr_q <= fetch_addr;
            jump_q <= 1'b0;
            pend_q <= 1'b0;
            st_q <= ST_SHIFT;
          end else if (fetch_req || busy_q) begin
            cs_n_q <= 1'b1;
            dual_data_q <= 1'b0;
            st_q <= ST_END;
          end
        end
        ST_END: begin
          dual_data_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: begin
          cs_n_q <= 1'b1;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // fetch cache window: base and count of newest sequential bytes
  assign cif.wr_en = cache_wr;
  assign cif.wr_idx = addr_q[CACHE_IDX_W-1:0];
  assign cif.wr_data = rx_next;
  assign cif.rd_idx = cur_addr[CACHE_IDX_W-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= 24'h0;
      clen_q <= 6'd0;
    end else if (cache_wr) begin
      if (jump_q) begin
        base_q <= addr_q;
        clen_q <= 6'd1;
      end else if (clen_q == 6'(CACHE_DEPTH)) begin
        base_q <= base_q + 24'd1;
      end else begin
        clen_q <= clen_q + 6'd1;
      end
    end
  end

  // boot signature capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_q <= 32'h0;
      boot_done_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      if (byte_done && mode_q == MODE_BOOT && idx_q >= IDX_DATA) begin
        sig_q <= {sig_q[23:0], rx_next};
      end
      if (st_q == ST_END && mode_q == MODE_BOOT) begin
        boot_done_q <= 1'b1;
        ext_q <= sig_q == SIG_VALUE;
      end
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_dual_q <= 1'b0;
      busy_q <= 1'b0;
      len_q <= LEN_RST;
      cmd_q <= CMD_RST;
      rsp_q <= RSP_RST;
    end else begin
      // clear happens only while busy and go is refused then, so a ctrl write never hides the clear
      if (st_q == ST_END && mode_q == MODE_BUF) begin
        busy_q <= 1'b0;
      end
      if (apb_wr && paddr == REG_CTRL) begin
        ctrl_dual_q <= pwdata[CTRL_DUAL];
        if (pwdata[CTRL_GO] && !busy_q && boot_done_q && len_q != '0) begin
          busy_q <= 1'b1;
        end
      end
      if (apb_wr && paddr == REG_LEN) begin
        len_q <= pwdata[LEN_W-1:0];
      end
      if (apb_wr && paddr == REG_CMD_LO) begin
        cmd_q[31:0] <= pwdata;
      end
      if (apb_wr && paddr == REG_CMD_HI) begin
        cmd_q[63:32] <= pwdata;
      end
      if (byte_done && mode_q == MODE_BUF && idx_q != '0 && idx_q <= BUF_BYTES) begin
        rsp_q[{idx_m1[2:0], 3'b000} +: 8] <= rx_next;
      end
    end
  end

  always_comb begin
    prdata = 32'h0;
    pslverr = 1'b0;
    case (paddr)
      REG_CTRL: prdata = {30'h0, ctrl_dual_q, busy_q};
      REG_LEN: prdata = {24'h0, len_q};
      REG_CMD_LO: prdata = cmd_q[31:0];
      REG_CMD_HI: prdata = cmd_q[63:32];
      REG_RSP_LO: prdata = rsp_q[31:0];
      REG_RSP_HI: prdata = rsp_q[63:32];
      REG_STAT: prdata = {28'h0, !cs_n_q, strap_fast_q, ext_q, boot_done_q};
      default: pslverr = psel && penable;
    endcase
  end

  assign pready = 1'b1;
  assign fetch_ready = ready_q;
  assign fetch_data = hit_q ? cif.rd_data : data_q;
  assign fetch_busy = !fetch_ok || pend_q || !(st_q == ST_IDLE || st_q == ST_HOLD);
  assign boot_done = boot_done_q;
  assign ext_exec_en = ext_q;
  assign flash_cs_n = cs_n_q;
  assign flash_sclk = sclk_q;
  assign serial_out_o = tx_q[7];
  // io0 turns round to an input for dual data
  assign serial_out_oe = !cs_n_q && !dual_data_q;

  // serial clocks since the last idle, for checking only
  logic [11:0] sck_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_cnt_q <= 12'd0;
    end else if (st_q == ST_IDLE) begin
      sck_cnt_q <= 12'd0;
    end else if (rise) begin
      sck_cnt_q <= sck_cnt_q + 12'd1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  buf_clocks_a: assert property ((st_q == ST_END && mode_q == MODE_BUF) |->
    sck_cnt_q == 12'({len_q, 3'b000})) else $error("buffered transfer clock count wrong");
  read_opcode_a: assert property (($fell(cs_n_q) && mode_q != MODE_BUF) |->
    tx_q == ((mode_q == MODE_FETCH && dual_sel_q) ? OP_DUAL : OP_READ)) else $error("wrong read opcode");
  dual_speed_a: assert property (dual_data_q |-> !strap_fast_q && !cs_n_q)
    else $error("dual data at fast speed");
  first_ready_a: assert property (cache_wr |=> fetch_ready && st_q == ST_HOLD ##1 !fetch_ready)
    else $error("ready not a single pulse after data byte");
  seq_stream_a: assert property ((st_q == ST_HOLD && seq_req) |=> !cs_n_q && st_q == ST_SHIFT)
    else $error("sequential fetch did not continue");
  jump_end_a: assert property ((st_q == ST_HOLD && fetch_req && !seq_req) |=> cs_n_q [*2])
    else $error("jump did not deselect flash");
  cache_hit_a: assert property ((st_q == ST_IDLE && boot_done_q && fetch_ok && fetch_req && cur_hit)
    |=> fetch_ready && hit_q && cs_n_q) else $error("cache hit not answered in one clock");
  cache_roll_a: assert property ((cache_wr && !jump_q && clen_q == 6'd32) |=>
    clen_q == 6'd32 && base_q == $past(base_q) + 24'd1) else $error("cache window did not slide");
  go_clear_a: assert property ($fell(busy_q) |-> cs_n_q && $past(cs_n_q))
    else $error("start bit cleared before deselect");
  boot_gate_a: assert property (!boot_done_q |-> !fetch_ready && !ext_q)
    else $error("fetch served before boot check");

  hit_seen_c: cover property (fetch_ready && hit_q);
  dual_seen_c: cover property (cache_wr && dual_data_q);
  buf_done_c: cover property ($fell(busy_q));
  ext_boot_c: cover property ($rose(ext_q));
endmodule : sfb_flash_fetch
`default_nettype wire

// ---- dv/sfb_flash_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sfb_flash_model #(
  parameter logic [7:0] ID0 = 8'h11, // id values are arbitrary
  parameter logic [7:0] ID1 = 8'h22,
  parameter logic [7:0] ID2 = 8'h33
) (
  // select and clock
  input wire logic cs_n,
  input wire logic sclk,
  // data lines
  input wire logic io0,
  input wire logic sig_bad,
  output logic io0_drv,
  output logic io1
);
  int n = 0;
  int sel = 0;
  logic [7:0] op = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [23:0] addr = 24'h0;
  logic [7:0] rx [12];
  function automatic logic [7:0] mem(input logic [23:0] a);
    case (a)
      24'h00fffa: return 8'h32;
      24'h00fffb: return 8'h44;
      24'h00fffc: return 8'h46;
      24'h00fffd: return sig_bad ? 8'h00 : 8'h55;
      default: return a[7:0] ^ a[15:8] ^ 8'h5a;
    endcase
  endfunction : mem
  function automatic logic [7:0] idb(input int k);
    return k == 0 ? ID0 : k == 1 ? ID1 : k == 2 ? ID2 : 8'(8'ha0 + k);
  endfunction : idb
  initial begin
    io0_drv = 1'b0;
    io1 = 1'b0;
  end
  always @(negedge cs_n) begin
    n = 0;
    sel++;
  end
  // command, address and written bytes are taken on rising clock
  always @(posedge sclk) begin
    if (!cs_n) begin
      sh = {sh[6:0], io0};
      if (n == 7) op = sh;
      if (n >= 8 && n < 32) addr = {addr[22:0], io0};
      if (n % 8 == 7 && n < 96) rx[n / 8] = sh;
      n++;
    end
  end
  // released lines show the inverse of their last level
  always @(posedge cs_n) begin
    io0_drv = ~io0_drv;
    io1 = ~io1;
  end
  always @(negedge sclk) begin : drive_p
    int k;
    logic [7:0] b;
    if (!cs_n) begin
      k = n - 40;
      if (op == 8'h3b && k >= 0) begin
        b = mem(addr + 24'(k / 4));
        io1 = b[7 - 2 * (k % 4)];
        io0_drv = b[6 - 2 * (k % 4)];
      end else if (op == 8'h0b && k >= 0) begin
        b = mem(addr + 24'(k / 8));
        io1 = b[7 - k % 8];
      end else if (op != 8'h0b && op != 8'h3b && n >= 8) begin
        b = idb((n - 8) / 8);
        io1 = b[7 - (n - 8) % 8];
      end
    end
  end
endmodule : sfb_flash_model
`default_nettype wire

// ---- dv/tb_spi_flash_boot_fetch_controller.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_spi_flash_boot_fetch_controller;
  import sfb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, fetch_req, strap, sig_bad;
  logic [7:0] paddr, fetch_data;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, fetch_ready, fetch_busy, boot_done, ext_exec_en;
  logic [23:0] fetch_addr;
  logic flash_cs_n, flash_sclk, so_o, so_oe, io1, drv0;
  wire logic io0;
  int err_total = 0;
  int tests_run = 0;
  logic [15:0] rs = 16'h028c;
  assign io0 = so_oe ? so_o : drv0;
  sfb_flash_fetch dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_data(fetch_data),
    .fetch_busy(fetch_busy), .boot_done(boot_done), .ext_exec_en(ext_exec_en), .flash_cs_n(flash_cs_n),
    .flash_sclk(flash_sclk), .serial_out_o(so_o), .serial_out_oe(so_oe), .serial_out_i(io0),
    .serial_in_line(io1), .serial_speed_strap(strap));
  sfb_flash_model flash (.cs_n(flash_cs_n), .sclk(flash_sclk), .io0(io0), .sig_bad(sig_bad),
    .io0_drv(drv0), .io1(io1));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // entered just after a rising edge, leaves one idle edge behind
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  task automatic fe(input logic [23:0] a, output logic [7:0] d, output int n);
    n = 0;
    while (fetch_busy !== 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge pclk);
    fetch_req <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (fetch_ready !== 1'b1 && n < 3000);
    d = fetch_data;
    chk("fetch_ready", 1, fetch_ready);
  endtask : fe
  task automatic rst(input logic s, input logic bad);
    logic [31:0] rd;
    logic er;
    int i;
    presetn <= 1'b0;
    strap <= s;
    sig_bad <= bad;
    repeat (16) @(posedge pclk);
    chk("cs_in_reset", 1, flash_cs_n);
    chk("boot_in_reset", 0, boot_done);
    presetn <= 1'b1;
    i = 0;
    while (boot_done !== 1'b1 && i < 5000) begin
      @(posedge pclk);
      i++;
    end
    chk("boot_done", 1, boot_done);
    chk("ext_exec", !bad, ext_exec_en);
    chk("sig_addr", 24'h00fffa, flash.addr);
    bus(0, REG_STAT, 0, rd, er);
    chk("strap", s, rd[STAT_FAST]);
    chk("stat_ext", !bad, rd[STAT_EXT]);
    bus(0, REG_LEN, 0, rd, er);
    chk("len_reset", LEN_RST, rd);
  endtask : rst
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // whole run needs about 8500 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end
  initial begin : main_p
    logic [31:0] rd;
    logic er;
    logic [7:0] d;
    logic [63:0] cmd, rsp;
    logic [23:0] b;
    int n, s0;
    logic [7:0] ops [8];
    int lens [8];
    {presetn, psel, penable, pwrite, fetch_req, strap, sig_bad} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fetch_addr = 24'h0;
    ops = '{8'h20, 8'h52, 8'hd8, 8'h02, 8'h9f, 8'h60, 8'h60, 8'h60};
    lens = '{4, 4, 4, 5, 4, 1, 1, 10};
    rst(0, 0);
    bus(0, 8'h40, 0, rd, er);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    rs = lfsr(rs);
    b = {4'h0, rs[11:0], 8'h00};
    s0 = flash.sel;
    for (int i = 0; i < 40; i++) begin
      fe(b + 24'(i), d, n);
      chk("stream_byte", flash.mem(b + 24'(i)), d);
    end
    chk("one_select", s0 + 1, flash.sel);
    chk("read_op", OP_READ, flash.op);
    fe(b + 24'd20, d, n);
    chk("hit_byte", flash.mem(b + 24'd20), d);
    chk("hit_no_select", s0 + 1, flash.sel);
    chk("cs_after_jump", 1, flash_cs_n);
    fe(b + 24'd30, d, n);
    chk("hit_latency", 1, n);
    chk("hit_byte2", flash.mem(b + 24'd30), d);
    fe(b + 24'd5, d, n);
    chk("old_byte_miss", s0 + 2, flash.sel);
    chk("miss_byte", flash.mem(b + 24'd5), d);
    bus(1, REG_CTRL, 32'h2, rd, er);
    for (int i = 0; i < 3; i++) begin
      fe(b + 24'h001000 + 24'(i), d, n);
      chk("dual_byte", flash.mem(b + 24'h001000 + 24'(i)), d);
    end
    chk("dual_op", OP_DUAL, flash.op);
    bus(1, REG_CTRL, 32'h0, rd, er);
    for (int i = 0; i < 8; i++) begin
      rs = lfsr(rs);
      cmd[31:0] = {rs, lfsr(rs)};
      rs = lfsr(lfsr(rs));
      cmd[63:32] = {rs, lfsr(rs)};
      cmd[7:0] = i < 5 ? ops[i] : {4'h6, rs[3:0]};
      bus(1, REG_CMD_LO, cmd[31:0], rd, er);
      bus(1, REG_CMD_HI, cmd[63:32], rd, er);
      bus(1, REG_LEN, 32'(lens[i]), rd, er);
      bus(0, REG_CMD_LO, 0, rd, er);
      chk("cmd_rw", cmd[31:0], rd);
      bus(1, REG_CTRL, 32'h1, rd, er);
      bus(0, REG_CTRL, 0, rd, er);
      chk("go_set", 1, rd[CTRL_GO]);
      n = 0;
      do begin
        bus(0, REG_CTRL, 0, rd, er);
        n++;
      end while (rd[CTRL_GO] === 1'b1 && n < 500);
      chk("go_cleared", 0, rd[CTRL_GO]);
      chk("cs_done", 1, flash_cs_n);
      chk("clocks", lens[i] * 8, flash.n);
      for (int k = 0; k < lens[i] && k < 12; k++)
        chk("sent_byte", k < 8 ? cmd[8*k+:8] : DONT_CARE, flash.rx[k]);
      bus(1, REG_RSP_LO, 32'hffffffff, rd, er);
      bus(0, REG_RSP_LO, 0, rd, er);
      rsp[31:0] = rd;
      bus(0, REG_RSP_HI, 0, rd, er);
      rsp[63:32] = rd;
      for (int k = 0; k < lens[i] - 1 && k < 8; k++)
        chk("resp_byte", flash.idb(k), rsp[8*k+:8]);
    end
    fe(24'h000080, d, n);
    chk("pre_reset_byte", flash.mem(24'h000080), d);
    rst(1, 0);
    bus(1, REG_CTRL, 32'h2, rd, er);
    fe(24'h000040, d, n);
    chk("fast_op", OP_READ, flash.op);
    chk("fast_byte", flash.mem(24'h000040), d);
    rst(0, 1);
    chk("internal_busy", 1, fetch_busy);
    report_and_stop();
  end
endmodule : tb_spi_flash_boot_fetch_controller
`default_nettype wire
